// *** rtl/serial_config_loader.sv ***
// serial configuration loader: reset handshake, serial load and startup
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "serial_config_loader_regs.svh"
module serial_config_loader #(
  parameter int POR_CYC = 1000, // power-on delay in clocks
  parameter int STATUS_MIN_CYC = `STATUS_MIN_CYC, // least health low time
  parameter int INIT_OSC_CYC = `INIT_OSC_CYC, // oscillator startup time
  parameter int USR_CYC = `USR_INIT_CYCLES // user clock startup edges
) (
  input wire logic hclk, // system clock, 100 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, words only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic [31:0] hrdata, // ahb read data
  input wire serial_config_loader_pkg::pin_in_t pins, // raw pin levels
  output serial_config_loader_pkg::pin_out_t drv // pin drives
);
  import serial_config_loader_pkg::*;

  localparam int REQ_LIM = `REQ_TO_LOW_CYC; // bound for request response
  localparam logic [19:0] CU_WAIT = 20'(`CU_WAIT_CYC); // user clock enable delay

  pin_in_t pin_s; // synchronised pins
  state_t state_reg; // sequence state
  state_t state_next; // next sequence state
  ctrl_t ctrl_reg; // control register
  logic [31:0] len_reg; // stream length in bits
  logic [31:0] cap_reg; // last captured bits
  logic [31:0] bit_cnt_reg; // bits received
  logic [19:0] cnt_reg; // general state timer
  logic [13:0] usr_cnt_reg; // user clock edges
  logic serial_config_clock_prev_reg; // previous host clock level
  logic usr_prev_reg; // previous user clock level
  logic [2:0] div_reg; // active clock divider
  logic serial_config_clock_reg; // active clock level
  logic [31:0] cmd_sr_reg; // command shifter
  logic [5:0] cmd_cnt_reg; // command falls seen
  logic cmd_out_reg; // command line level
  logic init_en_reg; // startup pin option latched
  logic wr_pend_reg; // write data phase pending
  logic [7:0] wr_addr_reg; // write address
  logic [31:0] rd_word; // read mux
  logic [31:0] ctrl_now; // control with forwarding
  logic [31:0] len_now; // length with forwarding
  pin_out_t drv_next; // next pin drives
  status_t stat; // status word
  logic ps_rise, ps_fall, usr_rise; // edge events
  logic as_run, as_tick, as_fall; // active clock events
  logic cap_ev, loaded; // capture events
  logic [31:0] step; // bits per capture
  logic [1:0] eff_range; // clamped clock range
  logic [2:0] half; // half period in clocks
  logic addr_ok; // address phase taken

  // half period for a clock range, rounded up so the maximum is never exceeded
  function automatic logic [2:0] half_period(input logic [1:0] rng);
    int f;
    case (rng)
      2'd0: f = `SERIAL_CONFIG_CLOCK_MAX0_X10;
      2'd1: f = `SERIAL_CONFIG_CLOCK_MAX1_X10;
      2'd2: f = `SERIAL_CONFIG_CLOCK_MAX2_X10;
      default: f = `SERIAL_CONFIG_CLOCK_MAX3_X10;
    endcase
    f = (`CLK_MHZ * 10 + 2 * f - 1) / (2 * f);
    half_period = (f < 1) ? 3'd1 : 3'(f);
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  sync2 #(.WIDTH(10)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d(pins),
    .q(pin_s)
  );

  // edge history of the sampled clocks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_config_clock_prev_reg <= 1'b0;
      usr_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      serial_config_clock_prev_reg <= pin_s.serial_config_clock;
      usr_prev_reg <= pin_s.user_clock;
    end
  end

  assign ps_rise = pin_s.serial_config_clock && !serial_config_clock_prev_reg;
  assign ps_fall = !pin_s.serial_config_clock && serial_config_clock_prev_reg;
  assign usr_rise = pin_s.user_clock && !usr_prev_reg;

  // ****************************************************************
  // ahb-lite slave, zero wait states
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;
  assign ctrl_now = (wr_pend_reg && wr_addr_reg == `CTRL_OFS) ? {23'h0, hwdata[8:0]} : ctrl_reg;
  assign len_now = (wr_pend_reg && wr_addr_reg == `LEN_OFS) ? hwdata : len_reg;

  // status word built from live state
  always_comb
  begin
    stat = '0;
    stat.state = state_reg;
    stat.health_level = pin_s.config_health_low;
    stat.complete_level = pin_s.configuration_complete;
    stat.user_mode = (state_reg == ST_USER);
    stat.error = (state_reg == ST_ERROR);
    stat.pdata_level = pin_s.passive_data_in;
  end

  // read mux; a write in its data phase is forwarded so back-to-back reads see it
  always_comb
  begin
    rd_word = 32'h0;
    if (haddr[31:8] == 24'h0)
    begin
      case (haddr[7:0])
        `CTRL_OFS: rd_word = ctrl_now;
        `LEN_OFS: rd_word = len_now;
        `STATUS_OFS: rd_word = stat;
        `CAPTURE_OFS: rd_word = cap_reg;
        `COUNT_OFS: rd_word = bit_cnt_reg;
        default: rd_word = 32'h0; // unmapped reads zero
      endcase
    end
  end

  // address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h0;
      hrdata <= 32'h0;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_ok && hwrite && haddr[31:8] == 24'h0;
      if (addr_ok)
        wr_addr_reg <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata <= rd_word;
    end
  end

  // writable registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= `CTRL_RST;
      len_reg <= `LEN_RST;
    end
    else if (ce && wr_pend_reg)
    begin
      if (wr_addr_reg == `CTRL_OFS)
        ctrl_reg <= {23'h0, hwdata[8:0]};
      else if (wr_addr_reg == `LEN_OFS)
        len_reg <= hwdata;
    end
  end

  // ****************************************************************
  // sequence state machine
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_POR: // health held low through power-on delay
        if (cnt_reg >= 20'(POR_CYC - 1))
          state_next = pin_s.reconfig_request_low ? ST_LOAD : ST_RESET;
      ST_RESET: // least low time, released once request is back high
        if (cnt_reg >= 20'(STATUS_MIN_CYC - 1) && pin_s.reconfig_request_low)
          state_next = ST_LOAD;
      ST_LOAD: // health pulled low from outside aborts the load
        if (cnt_reg > 20'd3 && !pin_s.config_health_low)
          state_next = ST_ERROR;
        else if (loaded)
          state_next = ST_DONE;
      ST_DONE: // passive host supplies two more falls before startup
        if (!ctrl_reg.passive_serial_mode || (ps_fall && cnt_reg == 20'd1))
          state_next = ST_INIT;
      ST_INIT: // startup clock source chosen by control
        if (ctrl_reg.usrclk_init)
        begin
          if (cnt_reg >= CU_WAIT && usr_rise && usr_cnt_reg == 14'(USR_CYC - 1))
            state_next = ST_USER;
        end
        else if (cnt_reg >= 20'(INIT_OSC_CYC - 1))
          state_next = ST_USER;
      ST_USER: state_next = ST_USER;
      ST_ERROR: state_next = ST_ERROR;
      default: state_next = ST_ERROR;
    endcase
    // a low request restarts from any state but power-on
    if (!pin_s.reconfig_request_low && state_reg != ST_POR)
      state_next = ST_RESET;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= ST_POR;
    else if (ce)
      state_reg <= state_next;
  end

  // state timer, cleared on every change; in done it counts host falls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= 20'h0;
    else if (ce)
    begin
      if (state_next != state_reg)
        cnt_reg <= 20'h0;
      else if (cnt_reg != 20'hfffff && (state_reg != ST_DONE || ps_fall))
        cnt_reg <= cnt_reg + 20'h1;
    end
  end

  // user clock edges, counted only once the input is enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      usr_cnt_reg <= 14'h0;
    else if (ce)
    begin
      if (state_reg != ST_INIT)
        usr_cnt_reg <= 14'h0;
      else if (cnt_reg >= CU_WAIT && usr_rise)
        usr_cnt_reg <= usr_cnt_reg + 14'h1;
    end
  end

  // ****************************************************************
  // active serial clock and command
  // ****************************************************************
  // fastest range clamped in chains; 50 and 100 ranges both reach hclk/2
  assign eff_range = (ctrl_reg.multi_dev && ctrl_reg.clk_range == 2'd3) ? 2'd2 : ctrl_reg.clk_range;
  assign half = half_period(eff_range);
  assign as_run = (state_reg == ST_LOAD) && !ctrl_reg.passive_serial_mode;
  assign as_tick = as_run && (div_reg == half - 3'd1);
  assign as_fall = as_tick && serial_config_clock_reg;

  // divider runs only while loading; the clock rests low otherwise
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_reg <= 3'h0;
      serial_config_clock_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!as_run)
      begin
        div_reg <= 3'h0;
        serial_config_clock_reg <= 1'b0;
      end
      else if (as_tick)
      begin
        div_reg <= 3'h0;
        serial_config_clock_reg <= !serial_config_clock_reg;
      end
      else
        div_reg <= div_reg + 3'h1;
    end
  end

  // read command shifted out after each falling edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_sr_reg <= `FLASH_READ_CMD;
      cmd_cnt_reg <= 6'h0;
      cmd_out_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (state_reg != ST_LOAD)
      begin
        cmd_sr_reg <= `FLASH_READ_CMD;
        cmd_cnt_reg <= 6'h0;
        cmd_out_reg <= 1'b0;
      end
      else if (as_fall && cmd_cnt_reg != `CMD_LAST)
      begin
        cmd_out_reg <= cmd_sr_reg[31];
        cmd_sr_reg <= {cmd_sr_reg[30:0], 1'b0};
        cmd_cnt_reg <= cmd_cnt_reg + 6'h1;
      end
    end
  end

  // ****************************************************************
  // data capture
  // ****************************************************************
  // passive samples on host rises active on own falls after the command
  assign cap_ev = (state_reg == ST_LOAD) && (ctrl_reg.passive_serial_mode ? ps_rise :
                  (as_fall && cmd_cnt_reg == `CMD_LAST));
  assign step = (ctrl_reg.quad && !ctrl_reg.passive_serial_mode) ? 32'd4 : 32'd1;
  assign loaded = cap_ev && (bit_cnt_reg + step >= len_reg);

  // bit counter and shifter; flash errors beyond a short stream are not detected
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bit_cnt_reg <= 32'h0;
      cap_reg <= 32'h0;
    end
    else if (ce)
    begin
      if (state_reg == ST_POR || state_reg == ST_RESET)
        bit_cnt_reg <= 32'h0;
      else if (cap_ev)
      begin
        bit_cnt_reg <= bit_cnt_reg + step;
        if (step == 32'd4)
          cap_reg <= {cap_reg[27:0], pin_s.active_data_lines};
        else if (ctrl_reg.passive_serial_mode)
          cap_reg <= {cap_reg[30:0], pin_s.passive_data_in};
        else
          cap_reg <= {cap_reg[30:0], pin_s.active_data_lines[0]};
      end
    end
  end

  // startup pin option followed from control throughout loading
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      init_en_reg <= 1'b0;
    else if (ce && state_reg == ST_RESET)
      init_en_reg <= 1'b0;
    else if (ce && state_reg == ST_LOAD)
      init_en_reg <= ctrl_reg.init_done_en;
  end

  // ****************************************************************
  // pin drives, registered
  // ****************************************************************
  always_comb
  begin
    drv_next = '0;
    drv_next.health_oe = (state_reg == ST_POR || state_reg == ST_RESET ||
                          state_reg == ST_ERROR);
    drv_next.complete_oe = (state_reg == ST_POR || state_reg == ST_RESET ||
                            state_reg == ST_LOAD || state_reg == ST_ERROR);
    drv_next.serial_config_clock_out = serial_config_clock_reg;
    drv_next.serial_config_clock_oe = !ctrl_reg.passive_serial_mode;
    drv_next.active_cmd_out = cmd_out_reg;
    drv_next.flash_select_low = !as_run;
    drv_next.init_done_oe = init_en_reg && (state_reg == ST_LOAD || state_reg == ST_DONE ||
                            state_reg == ST_INIT);
    drv_next.user_mode = (state_reg == ST_USER);
    if (state_reg == ST_USER && ctrl_reg.passive_serial_mode)
    begin
      drv_next.passive_data_oe = ctrl_reg.user_io_drive;
      drv_next.passive_data_out = ctrl_reg.user_io_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      drv <= '{health_oe: 1'b1, complete_oe: 1'b1, flash_select_low: 1'b1, default: 1'b0};
    else if (ce)
      drv <= drv_next;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_req_pins_low: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    $fell(pin_s.reconfig_request_low) |-> ##[1:REQ_LIM] (drv.health_oe && drv.complete_oe))
    else $error("request low did not pull both pins low");
  a_por_health: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (state_reg == ST_POR) |=> drv.health_oe)
    else $error("health released during power-on delay");
  a_complete_low: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (state_reg == ST_LOAD) |=> drv.complete_oe && !drv.complete_out)
    else $error("completion released during load");
  a_whole_stream: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    $rose(state_reg == ST_DONE) |-> bit_cnt_reg >= len_reg)
    else $error("completion before whole stream");
  a_health_min: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (state_reg == ST_RESET ##1 state_reg == ST_LOAD) |->
      $past(cnt_reg) >= 20'(STATUS_MIN_CYC - 1))
    else $error("health low time too short");
  a_user_pins: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (state_reg == ST_USER) |=> drv.user_mode && !drv.health_oe && !drv.complete_oe)
    else $error("user mode with pins held low");
  a_osc_startup: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (state_reg == ST_INIT ##1 state_reg == ST_USER && !ctrl_reg.usrclk_init) |->
      $past(cnt_reg) == 20'(INIT_OSC_CYC - 1))
    else $error("oscillator startup time wrong");
  a_usr_startup: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (state_reg == ST_INIT ##1 state_reg == ST_USER && ctrl_reg.usrclk_init) |->
      $past(usr_cnt_reg) == 14'(USR_CYC - 1) && $past(cnt_reg) >= CU_WAIT)
    else $error("user clock startup count wrong");
  a_init_done_low: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    ($rose(state_reg == ST_LOAD) && ctrl_reg.init_done_en) |-> ##2 drv.init_done_oe)
    else $error("startup pin not driven low");
  a_cmd_on_fall: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    ($changed(cmd_out_reg) && state_reg == ST_LOAD) |-> $past(as_fall))
    else $error("command changed off a falling edge");
  a_ps_on_rise: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    ($changed(bit_cnt_reg) && $past(state_reg) == ST_LOAD && ctrl_reg.passive_serial_mode)
      |-> $past(ps_rise))
    else $error("passive bit taken off a rising edge");
  a_chain_range: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (as_run && ctrl_reg.multi_dev) |-> eff_range != 2'd3)
    else $error("chain clock at fastest range");
  a_quad_step: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (cap_ev && ctrl_reg.quad && !ctrl_reg.passive_serial_mode) |=>
      bit_cnt_reg == $past(bit_cnt_reg) + 32'd4)
    else $error("quad capture did not take four bits");
  c_user: cover property (@(posedge hclk) disable iff (!hresetn) $rose(state_reg == ST_USER));
  c_error: cover property (@(posedge hclk) disable iff (!hresetn) $rose(state_reg == ST_ERROR));
  c_reconf: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_USER ##1 state_reg == ST_RESET);
  c_quad: cover property (@(posedge hclk) disable iff (!hresetn)
    cap_ev && ctrl_reg.quad && !ctrl_reg.passive_serial_mode);
endmodule

// *** rtl/serial_config_loader_regs.svh ***
// register offsets, reset values and timing counts of the serial configuration loader
`ifndef SERIAL_CONFIG_LOADER_REGS_SVH
`define SERIAL_CONFIG_LOADER_REGS_SVH

// ****************************************************************
// register map, byte offsets
// ****************************************************************
`define CTRL_OFS 8'h00
`define LEN_OFS 8'h04
`define STATUS_OFS 8'h08
`define CAPTURE_OFS 8'h0c
`define COUNT_OFS 8'h10
`define CTRL_RST 32'h0000_0000
`define LEN_RST 32'h0000_1000
`define FLASH_READ_CMD 32'h0300_0000
`define CMD_LAST 6'd33

// ****************************************************************
// timing, system clock in MHz
// ****************************************************************
`define CLK_MHZ 100
`define REQ_TO_LOW_NS 600
`define REQ_TO_LOW_CYC (`REQ_TO_LOW_NS * `CLK_MHZ / 1000)
`define STATUS_MIN_US 268
`define STATUS_MIN_CYC (`STATUS_MIN_US * `CLK_MHZ)
`define INIT_OSC_MIN_US 175
`define INIT_OSC_CYC (`INIT_OSC_MIN_US * `CLK_MHZ)
`define USR_INIT_CYCLES 8576
`define CU_SERIAL_CONFIG_CLOCK_PERIODS 4
`define SERIAL_CONFIG_CLOCK_MIN_MHZ_X10 53
`define CU_WAIT_CYC ((`CU_SERIAL_CONFIG_CLOCK_PERIODS * `CLK_MHZ * 10 + `SERIAL_CONFIG_CLOCK_MIN_MHZ_X10 - 1) / `SERIAL_CONFIG_CLOCK_MIN_MHZ_X10)
`define SERIAL_CONFIG_CLOCK_MAX0_X10 125
`define SERIAL_CONFIG_CLOCK_MAX1_X10 250
`define SERIAL_CONFIG_CLOCK_MAX2_X10 500
`define SERIAL_CONFIG_CLOCK_MAX3_X10 1000

`endif

// *** rtl/serial_config_loader_pkg.sv ***
// types shared by the serial configuration loader
package serial_config_loader_pkg;

  // loader sequence states
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_RESET = 3'b001,
    ST_LOAD = 3'b010,
    ST_DONE = 3'b011,
    ST_INIT = 3'b100,
    ST_USER = 3'b101,
    ST_ERROR = 3'b110
  } state_t;

  // control register layout, bit 31 down to bit 0
  typedef struct packed {
    logic [22:0] rsvd;
    logic user_io_val;
    logic user_io_drive;
    logic init_done_en;
    logic usrclk_init;
    logic multi_dev;
    logic [1:0] clk_range;
    logic quad;
    logic passive_serial_mode;
  } ctrl_t;

  // status register layout, bit 31 down to bit 0
  typedef struct packed {
    logic [23:0] rsvd;
    logic pdata_level;
    logic error;
    logic user_mode;
    logic complete_level;
    logic health_level;
    state_t state;
  } status_t;

  // raw pin levels as seen at the device
  typedef struct packed {
    logic reconfig_request_low;
    logic config_health_low;
    logic configuration_complete;
    logic serial_config_clock;
    logic passive_data_in;
    logic user_clock;
    logic [3:0] active_data_lines;
  } pin_in_t;

  // pin drive levels and enables
  typedef struct packed {
    logic health_out;
    logic health_oe;
    logic complete_out;
    logic complete_oe;
    logic serial_config_clock_out;
    logic serial_config_clock_oe;
    logic active_cmd_out;
    logic flash_select_low;
    logic passive_data_out;
    logic passive_data_oe;
    logic init_done_out;
    logic init_done_oe;
    logic user_mode;
  } pin_out_t;

endpackage

// *** rtl/sync2.sv ***
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [WIDTH-1:0] d, // asynchronous levels
  output logic [WIDTH-1:0] q // synchronised levels
);
  logic [WIDTH-1:0] meta_reg; // first stage, read only by q

  // ****************************************************************
  // two stages, reset to zero
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// *** dv/config_host.sv ***
// passive serial host model: drives link clock and data
`timescale 1ns/1ps
module config_host (
  output logic sclk, // serial config clock
  output logic sdata // serial data
);
  // clock stands low outside frames
  initial
  begin
    sclk = 1'b0;
    sdata = 1'b0;
  end
  // one bit per 125 ns, data set up before the rise
  task automatic bit_out(input logic b);
    sdata = b;
    #31.25 sclk = 1'b1;
    #62.5 sclk = 1'b0;
    #31.25; // data held to the end of the bit, next bit sets it anew
  endtask
  // two extra falls after completion, then park low
  task automatic finish();
    repeat (2)
    begin
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
  endtask
endmodule

// *** dv/serial_config_loader_tb.sv ***
// testbench of the serial configuration loader
`timescale 1ns/1ps
`include "serial_config_loader_regs.svh"
module serial_config_loader_tb;
  import serial_config_loader_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sclk, sdata, req_low, b, hl;
  time t0;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, cap;
  pin_in_t pins;
  pin_out_t drv;
  int mismatches, comparisons, cnt;
  config_host host_u (.sclk(sclk), .sdata(sdata));
  serial_config_loader #(.POR_CYC(20), .STATUS_MIN_CYC(50), .INIT_OSC_CYC(40)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pins(pins), .drv(drv));
  // open-drain health and completion wires with pull-ups
  assign pins = {req_low, ~drv.health_oe & hl, ~drv.complete_oe, sclk, sdata, 1'b0, 4'hf};
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // single ahb transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: whole run needs well under 20 us
  initial
  begin
    #60us;
    mismatches++;
    results();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    req_low = 1'b1;
    hl = 1'b1;
    cap = 32'h0;
    rd = $urandom(32'h4a5e627a);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("health_por", 32'h1, drv.health_oe);
    check("complete_por", 32'h1, drv.complete_oe);
    ahb(1'b0, `CTRL_OFS, 32'h0);
    check("ctrl_rst", `CTRL_RST, rd);
    check("hresp", 32'h0, hresp);
    ahb(1'b0, `LEN_OFS, 32'h0);
    check("len_rst", `LEN_RST, rd);
    ahb(1'b0, 32'h14, 32'h0);
    check("unmapped", 32'h0, rd);
    ahb(1'b1, `CTRL_OFS, 32'h1); // passive mode, oscillator startup
    ahb(1'b1, `LEN_OFS, 32'd16);
    $display("register test done");
    req_low <= 1'b0;
    repeat (5) @(posedge hclk);
    check("health_req", 32'h1, drv.health_oe);
    check("complete_req", 32'h1, drv.complete_oe);
    repeat (200) @(posedge hclk);
    req_low <= 1'b1;
    for (cnt = 0; cnt < 100 && drv.health_oe !== 1'b0; cnt++) @(posedge hclk);
    check("health_rel", 32'h0, drv.health_oe);
    repeat (200) @(posedge hclk);
    for (int i = 0; i < 16; i++)
    begin
      b = 1'($urandom);
      check("complete_load", 32'h1, drv.complete_oe);
      host_u.bit_out(b);
      cap = {cap[30:0], b};
    end
    for (cnt = 0; cnt < 20 && drv.complete_oe !== 1'b0; cnt++) @(negedge hclk);
    t0 = $time;
    check("complete_rel", 32'h0, drv.complete_oe);
    ahb(1'b0, `CAPTURE_OFS, 32'h0);
    check("capture", cap, rd);
    ahb(1'b0, `COUNT_OFS, 32'h0);
    check("count", 32'd16, rd);
    check("no_user_yet", 32'h0, drv.user_mode);
    host_u.finish();
    for (cnt = 0; cnt < 300 && drv.user_mode !== 1'b1; cnt++) @(posedge hclk);
    check("user_mode", 32'h1, drv.user_mode);
    check("init_time", 32'h1, 32'(($time - t0) >= 64'd400));
    check("pdata_free", 32'h0, drv.passive_data_oe);
    ahb(1'b0, `STATUS_OFS, 32'h0);
    check("status", 32'h3d, rd & 32'h3f);
    $display("load test done");
    ahb(1'b1, `CTRL_OFS, 32'h41); // passive, startup pin enabled
    req_low <= 1'b0;
    repeat (100) @(posedge hclk);
    req_low <= 1'b1;
    for (cnt = 0; cnt < 100 && drv.health_oe !== 1'b0; cnt++) @(posedge hclk);
    repeat (3) @(posedge hclk);
    check("init_pin_load", 32'h1, drv.init_done_oe);
    hl <= 1'b0; // health pulled low from outside during loading
    repeat (8) @(posedge hclk);
    check("error_health", 32'h1, drv.health_oe);
    check("error_complete", 32'h1, drv.complete_oe);
    hl <= 1'b1;
    req_low <= 1'b0;
    repeat (100) @(posedge hclk);
    req_low <= 1'b1;
    for (cnt = 0; cnt < 100 && drv.health_oe !== 1'b0; cnt++) @(posedge hclk);
    check("restart", 32'h0, drv.health_oe);
    $display("error test done");
    results();
  end
endmodule
